// ==== maintenance_life_alert.sv ====
/*
  Service-life supervision: holds four life percentages, compares them with the
  threshold, raises the maintenance warning and drives the allocated output pin.
  Assumes inputs synchronous to REF_CLK; the restart is a pulse from drive control.
*/
module maintenance_life_alert (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // Life estimate updates
  input wire logic LIFE_UPDATE,
  input wire logic [6:0] FAN_LIFE,
  input wire logic [6:0] CAP_LIFE,
  input wire logic [6:0] INRUSH_LIFE,
  input wire logic [6:0] BRAKE_LIFE,
  // Environment values
  input wire logic [6:0] DRIVE_ENV,
  input wire logic [6:0] MOTOR_ENV,
  // Configuration
  input wire logic RESTART,
  input wire logic MAINT_WARN_ENABLE_CFG,
  input wire logic [2:0] OUTPUT_PIN_ALLOCATION_CFG,
  // Monitor read port
  input wire logic [2:0] MONITOR_ITEM,
  output logic [6:0] MONITOR_DATA,
  output logic MONITOR_VALID,
  // Warning and output
  output logic MAINT_WARNING,
  output logic [7:0] MAINT_WARNING_CODE,
  output logic MAINT_DUE_OUT,
  output logic [2:0] PIN_OUT,
  output logic [2:0] PIN_OE
);

  //////////////////////////////////////////////////////////////////////////////

  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_RUN = 2'b01
  } mode_type;

  typedef struct packed {
    mode_type mode;
    logic warn_en;
    logic [6:0] fan;
    logic [6:0] cap;
    logic [6:0] inrush;
    logic [6:0] brake;
    logic eval;
    logic warning;
    logic [7:0] code;
    logic due;
    logic [2:0] pin_out;
    logic [2:0] pin_oe;
    logic [6:0] mon_data;
    logic mon_valid;
  } state_type;

  state_type cur;
  state_type next_cur;
  logic [3:0] low;

  life_compare #(
    .UNITS(maint_pkg::NUM_UNITS),
    .WIDTH(maint_pkg::LIFE_W)
  ) u_cmp (
    .life({cur.brake, cur.cap, cur.inrush, cur.fan}),
    .threshold(maint_pkg::LIFE_THRESHOLD),
    .low(low)
  );

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_cur = cur;
    next_cur.eval = 1'b0;
    // Enable is sampled only at restart and in the boot cycle after reset, so a live change cannot toggle warnings.
    if (cur.mode == ST_BOOT || RESTART) begin
      next_cur.mode = ST_RUN;
      next_cur.warn_en = MAINT_WARN_ENABLE_CFG;
    end
    // Values above full scale are clamped so the scale stays 0 to 100.
    if (LIFE_UPDATE) begin
      next_cur.fan = (FAN_LIFE > maint_pkg::LIFE_FULL) ? maint_pkg::LIFE_FULL : FAN_LIFE;
      next_cur.cap = (CAP_LIFE > maint_pkg::LIFE_FULL) ? maint_pkg::LIFE_FULL : CAP_LIFE;
      next_cur.inrush = (INRUSH_LIFE > maint_pkg::LIFE_FULL) ? maint_pkg::LIFE_FULL : INRUSH_LIFE;
      next_cur.brake = (BRAKE_LIFE > maint_pkg::LIFE_FULL) ? maint_pkg::LIFE_FULL : BRAKE_LIFE;
      next_cur.eval = 1'b1;
    end
    // Outputs recomputed every cycle; they settle two clocks after an update.
    next_cur.due = |low;
    next_cur.warning = cur.warn_en & (|low);
    next_cur.code = (cur.warn_en & (|low)) ? maint_pkg::MAINT_WARNING_CODE : maint_pkg::NO_WARNING_CODE;
    // Codes above the pin count select nothing, so a bad setting leaves every contact open.
    for (int i = 0; i < maint_pkg::NUM_PINS; i++) begin
      // Only the allocated pin is enabled; closed contact means driven high.
      next_cur.pin_oe[i] = (OUTPUT_PIN_ALLOCATION_CFG == 3'(i + 1));
      next_cur.pin_out[i] = (OUTPUT_PIN_ALLOCATION_CFG == 3'(i + 1)) & (|low);
    end
    // Six contiguous monitor items: two environment, four life values.
    next_cur.mon_valid = MONITOR_ITEM <= maint_pkg::LIFE_MONITOR_LAST_ITEM;
    unique case (MONITOR_ITEM)
      3'h0: next_cur.mon_data = DRIVE_ENV;
      3'h1: next_cur.mon_data = MOTOR_ENV;
      3'h2: next_cur.mon_data = cur.fan;
      3'h3: next_cur.mon_data = cur.cap;
      3'h4: next_cur.mon_data = cur.inrush;
      3'h5: next_cur.mon_data = cur.brake;
      default: next_cur.mon_data = maint_pkg::LIFE_ZERO;
    endcase
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    // Lives come back at full scale so that a reset cannot raise a false maintenance alarm.
    if (SYS_RST) begin
      cur <= '{mode: ST_BOOT, warn_en: 1'b0, fan: maint_pkg::LIFE_FULL, cap: maint_pkg::LIFE_FULL,
               inrush: maint_pkg::LIFE_FULL, brake: maint_pkg::LIFE_FULL, eval: 1'b0, warning: 1'b0,
               code: maint_pkg::NO_WARNING_CODE, due: 1'b0, pin_out: 3'h0, pin_oe: 3'h0,
               mon_data: maint_pkg::LIFE_ZERO, mon_valid: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign MONITOR_DATA = cur.mon_data;
  assign MONITOR_VALID = cur.mon_valid;
  assign MAINT_WARNING = cur.warning;
  assign MAINT_WARNING_CODE = cur.code;
  assign MAINT_DUE_OUT = cur.due;
  assign PIN_OUT = cur.pin_out;
  assign PIN_OE = cur.pin_oe;

  //////////////////////////////////////////////////////////////////////////////

  sequence s_low_update;
    LIFE_UPDATE && (FAN_LIFE <= maint_pkg::LIFE_THRESHOLD);
  endsequence

  sequence s_due_follows;
    ##2 MAINT_DUE_OUT;
  endsequence

  // Any one of the four units at or below the threshold must raise the due output two clocks later.
  sequence s_any_low_update;
    LIFE_UPDATE && (FAN_LIFE <= maint_pkg::LIFE_THRESHOLD || CAP_LIFE <= maint_pkg::LIFE_THRESHOLD ||
                    INRUSH_LIFE <= maint_pkg::LIFE_THRESHOLD || BRAKE_LIFE <= maint_pkg::LIFE_THRESHOLD);
  endsequence

  sequence s_all_high;
    cur.fan > maint_pkg::LIFE_THRESHOLD && cur.cap > maint_pkg::LIFE_THRESHOLD &&
    cur.inrush > maint_pkg::LIFE_THRESHOLD && cur.brake > maint_pkg::LIFE_THRESHOLD;
  endsequence

  a_due_after_low: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    s_low_update |-> s_due_follows) else $error("due output missed a low fan life");

  a_due_any_low: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    s_any_low_update |-> s_due_follows) else $error("due output missed a low life value");

  a_idle_all_high: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    s_all_high |=> !MAINT_DUE_OUT)
    else $error("due output active with all lives high");

  // The warning answers to the enable held in the cycle before, not to one just resampled.
  a_warn_gated: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    MAINT_WARNING |-> $past(cur.warn_en) && MAINT_DUE_OUT) else $error("warning without enable or due");

  a_warn_detect: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (cur.warn_en && $past(cur.warn_en) && $past(|low)) |-> MAINT_WARNING) else $error("warning not raised");

  a_warn_all_high: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    s_all_high |=> !MAINT_WARNING) else $error("warning active with all lives high");

  a_warn_off_due: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (!$past(SYS_RST) && !$past(cur.warn_en) && $past(|low)) |-> (MAINT_DUE_OUT && !MAINT_WARNING))
    else $error("due output lost with warnings disabled");

  a_code_match: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    MAINT_WARNING_CODE == (MAINT_WARNING ? maint_pkg::MAINT_WARNING_CODE : maint_pkg::NO_WARNING_CODE))
    else $error("warning code disagrees with warning");

  a_enable_stable: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    ($past(cur.mode) == ST_RUN && !$past(RESTART)) |-> $stable(cur.warn_en))
    else $error("enable changed without restart");

  a_enable_sampled: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (!$past(SYS_RST) && ($past(cur.mode) == ST_BOOT || $past(RESTART))) |->
      cur.warn_en == $past(MAINT_WARN_ENABLE_CFG)) else $error("enable not taken at restart");

  a_pin_unalloc: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    ($past(OUTPUT_PIN_ALLOCATION_CFG) == maint_pkg::PIN_UNALLOCATED) |-> (PIN_OE == 3'h0 && PIN_OUT == 3'h0))
    else $error("unallocated pin driven");

  a_pin_high_codes: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    ($past(OUTPUT_PIN_ALLOCATION_CFG) > 3'(maint_pkg::NUM_PINS)) |-> (PIN_OE == 3'h0 && PIN_OUT == 3'h0))
    else $error("pin driven by an invalid allocation");

  a_pin_follows: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    ($past(OUTPUT_PIN_ALLOCATION_CFG) == 3'h1) |-> PIN_OUT[0] == MAINT_DUE_OUT) else $error("pin differs from due");

  a_pin_two_follows: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (!$past(SYS_RST) && $past(OUTPUT_PIN_ALLOCATION_CFG) == 3'h2) |->
      (PIN_OE == 3'h2 && PIN_OUT[1] == MAINT_DUE_OUT)) else $error("second pin differs from due");

  a_pin_three_follows: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (!$past(SYS_RST) && $past(OUTPUT_PIN_ALLOCATION_CFG) == 3'h3) |->
      (PIN_OE == 3'h4 && PIN_OUT[2] == MAINT_DUE_OUT)) else $error("third pin differs from due");

  a_life_range: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    cur.fan <= maint_pkg::LIFE_FULL && cur.cap <= maint_pkg::LIFE_FULL &&
    cur.inrush <= maint_pkg::LIFE_FULL && cur.brake <= maint_pkg::LIFE_FULL) else $error("life above full scale");

  a_monitor_item: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (MONITOR_ITEM == 3'h2) |=> MONITOR_VALID && MONITOR_DATA == $past(cur.fan)) else $error("monitor fan item wrong");

  a_monitor_env: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (MONITOR_ITEM == 3'h0) |=> MONITOR_VALID && MONITOR_DATA == $past(DRIVE_ENV))
    else $error("monitor environment item wrong");

  a_monitor_range: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (MONITOR_ITEM > maint_pkg::LIFE_MONITOR_LAST_ITEM) |=> !MONITOR_VALID && MONITOR_DATA == maint_pkg::LIFE_ZERO)
    else $error("monitor item outside the group answered");

  a_eval_timing: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    cur.eval |=> (MAINT_DUE_OUT == $past(|low))) else $error("evaluation late");

  a_eval_pulse: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    !$past(SYS_RST) |-> cur.eval == $past(LIFE_UPDATE)) else $error("update strobe not taken");

endmodule

// ==== maint_pkg.sv ====
/*
  Constants for the service-life supervision block: life scale, warning threshold,
  allocation codes, monitor item numbering and reset values.
  Assumes life values arrive as whole percentages, 0 to 100, with an update strobe.
*/
// Overview of operation
// - Life values are percentages: 100 when new, falling with use, 0 at replacement.
// - When enabled, warn if fan, capacitor, inrush or brake life is at most 10%.
// - Warning enable: 0 suppresses (default), 1 detects; change applies after restart.
// - Maintenance output is active while any life value is at most 10%.
// - Maintenance output is inactive only while all four values exceed 10%.
// - Maintenance output follows the comparison even with warnings disabled.
// - Maintenance output reaches a pin only when allocated; unallocated drives nothing.
// - Environment and life values are readable as a contiguous group of monitor items.
package maint_pkg;
  localparam int LIFE_W = 7;
  localparam logic [6:0] LIFE_FULL = 7'h64;
  localparam logic [6:0] LIFE_ZERO = 7'h00;
  localparam logic [6:0] LIFE_THRESHOLD = 7'h0A;
  localparam int NUM_UNITS = 4;
  localparam int PIN_SEL_W = 3;
  localparam int NUM_PINS = 3;
  localparam logic [2:0] PIN_UNALLOCATED = 3'h0;
  localparam int ITEM_W = 3;
  localparam logic [2:0] LIFE_MONITOR_FIRST_ITEM = 3'h0;
  localparam logic [2:0] LIFE_MONITOR_LAST_ITEM = 3'h5;
  localparam logic [7:0] MAINT_WARNING_CODE = 8'hB0;
  localparam logic [7:0] NO_WARNING_CODE = 8'h00;
endpackage

// ==== life_compare.sv ====
/*
  Threshold comparator for the four life values.
  Assumes the caller registers the result; purely combinational.
*/
module life_compare #(
  parameter int UNITS = 4,
  parameter int WIDTH = 7
) (
  input wire logic [UNITS*WIDTH-1:0] life,
  input wire logic [WIDTH-1:0] threshold,
  output logic [UNITS-1:0] low
);
  genvar g;
  generate
    for (g = 0; g < UNITS; g++) begin : g_cmp
      // Equal to the threshold counts as worn out.
      assign low[g] = life[g*WIDTH +: WIDTH] <= threshold;
    end
  endgenerate
endmodule

// ==== host_contact_reader.sv ====
/*
  Host controller side: reads the three allocatable output contacts.
  Assumes an open contact reads low through the host's pull-down.
*/
module host_contact_reader (
  // Pins from the drive
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe,
  // Contact state seen by the host
  output logic closed
);
  // An undriven pin is an open contact, so only enabled pins count.
  assign closed = |(pin_oe & pin_out);
endmodule

// ==== maintenance_life_alert_tb_top.sv ====
/*
  Self-checking bench for the service-life supervision block.
  Assumes results settle two clocks after an update strobe and inputs move on falling edges.
*/
module maintenance_life_alert_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 0, sys_rst = 1, life_update = 0, restart = 0, warn_en = 0;
  logic [6:0] fan = 7'h64, cap = 7'h64, inr = 7'h64, brk = 7'h64, env_d = 7'h2A, env_m = 7'h15;
  logic [2:0] alloc = 3'h1, item = 3'h0, pin_out, pin_oe;
  logic [6:0] mon_data;
  logic [7:0] code;
  logic mon_valid, warn, due, closed;
  int n_fail = 0, tests_run = 0;
  maintenance_life_alert dut_u (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .LIFE_UPDATE(life_update),
    .FAN_LIFE(fan), .CAP_LIFE(cap), .INRUSH_LIFE(inr), .BRAKE_LIFE(brk), .DRIVE_ENV(env_d),
    .MOTOR_ENV(env_m), .RESTART(restart), .MAINT_WARN_ENABLE_CFG(warn_en),
    .OUTPUT_PIN_ALLOCATION_CFG(alloc), .MONITOR_ITEM(item), .MONITOR_DATA(mon_data),
    .MONITOR_VALID(mon_valid), .MAINT_WARNING(warn), .MAINT_WARNING_CODE(code),
    .MAINT_DUE_OUT(due), .PIN_OUT(pin_out), .PIN_OE(pin_oe));
  host_contact_reader host_u (.pin_out(pin_out), .pin_oe(pin_oe), .closed(closed));
  initial forever #2.5 ref_clk = ~ref_clk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk_val(string what, logic [7:0] exp, logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(negedge ref_clk);
  endtask
  function automatic logic low();
    return fan <= maint_pkg::LIFE_THRESHOLD || cap <= maint_pkg::LIFE_THRESHOLD ||
      inr <= maint_pkg::LIFE_THRESHOLD || brk <= maint_pkg::LIFE_THRESHOLD;
  endfunction
  task automatic update(logic [6:0] f, logic [6:0] c, logic [6:0] i, logic [6:0] b);
    {fan, cap, inr, brk, life_update} = {f, c, i, b, 1'b1};
    step(1);
    life_update = 0;
    step(2);
  endtask
  task automatic check_outs(logic en);
    logic l;
    l = low();
    chk_val("due", 8'(l), 8'(due));
    chk_val("warning", 8'(l & en), 8'(warn));
    chk_val("code", (l & en) ? maint_pkg::MAINT_WARNING_CODE : 8'h00, code);
    chk_val("contact", 8'(l && alloc inside {[1:3]}), 8'(closed));
  endtask
  task automatic scan();
    logic [6:0] tab [8];
    tab = '{env_d, env_m, fan, cap, inr, brk, 7'h00, 7'h00};
    for (int k = 0; k < 8; k++) begin
      item = 3'(k);
      step(1);
      chk_val("monitor", 8'(tab[k]), 8'(mon_data));
      chk_val("valid", 8'(k < 6), 8'(mon_valid));
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    final_report();
  end
  initial begin
    void'($urandom(32'hbb079290));
    step(16);
    sys_rst = 0;
    step(2);
    scan();
    $display("test reset values done");
    update(7'h0A, 7'h64, 7'h64, 7'h64);
    check_outs(0);
    warn_en = 1;
    step(3);
    check_outs(0);
    restart = 1;
    step(1);
    restart = 0;
    step(2);
    check_outs(1);
    $display("test enable at restart done");
    update(7'h0B, 7'h0B, 7'h0B, 7'h0B);
    check_outs(1);
    for (int u = 0; u < 4; u++) begin
      update(u == 0 ? 7'h0A : 7'h0B, u == 1 ? 7'h0A : 7'h0B, u == 2 ? 7'h0A : 7'h0B, u == 3 ? 7'h0A : 7'h0B);
      check_outs(1);
    end
    $display("test threshold boundary done");
    for (int a = 0; a < 8; a++) begin
      alloc = 3'(a);
      step(2);
      chk_val("pin enable", (a >= 1 && a <= 3) ? 8'(1 << (a - 1)) : 8'h00, 8'(pin_oe));
      check_outs(1);
    end
    $display("test pin allocation done");
    repeat (40) begin
      alloc = 3'($urandom_range(3, 0));
      update(7'($urandom_range(100)), 7'($urandom_range(100)), 7'($urandom_range(100)), 7'($urandom_range(30)));
      check_outs(1);
    end
    scan();
    $display("test random lives done");
    sys_rst = 1;
    {fan, cap, inr, brk} = {4{maint_pkg::LIFE_FULL}};
    step(2);
    sys_rst = 0;
    step(2);
    check_outs(1);
    update(7'h05, 7'h64, 7'h64, 7'h64);
    check_outs(1);
    $display("test enable at reset done");
    final_report();
  end
endmodule
